/* core/ctmie_pkg.sv */
package ctmie_pkg;

  // Widths of the fields that travel between the decoder, the timer and the top.
  localparam int unsigned OPCODE_W = 8;
  localparam int unsigned BYTES_W  = 2;
  localparam int unsigned CYCLES_W = 4;

  // Longest execution time of any instruction, in system clock cycles.
  localparam logic [CYCLES_W-1:0] MAX_CYCLES = 4'h8;
  // Cycles that a failed conditional branch saves against the taken branch.
  localparam logic [CYCLES_W-1:0] NOT_TAKEN_SAVING = 4'h1;
  // One clock cycle, the shortest instruction and the timer's final step.
  localparam logic [CYCLES_W-1:0] ONE_CYCLE = 4'h1;

  // Bit positions of the status word flags inside the flag-effect mask.
  localparam int unsigned FLAG_CY = 2;
  localparam int unsigned FLAG_AC = 1;
  localparam int unsigned FLAG_OV = 0;

  // The only opcode that the classic instruction set leaves undefined.
  localparam logic [OPCODE_W-1:0] UNDEFINED_OPCODE = 8'hA5;

  // Static properties of one opcode.
  typedef struct packed {
    logic                legal;      // Opcode is defined.
    logic                cond;       // Conditional branch with two timings.
    logic [BYTES_W-1:0]  bytes;      // Program bytes occupied.
    logic [CYCLES_W-1:0] cyc_taken;  // Cycles, or cycles when the branch is taken.
    logic [2:0]          flags;      // Status word flags written: CY, AC, OV.
  } ctmie_decode_t;

  // Record of one finished instruction.
  typedef struct packed {
    logic                valid;      // One-cycle completion pulse.
    logic                illegal;    // Undefined opcode was executed as a no-op.
    logic                taken;      // Branch taken (always 1 for non-conditional).
    logic [OPCODE_W-1:0] opcode;
    logic [BYTES_W-1:0]  bytes;
    logic [CYCLES_W-1:0] cycles;     // Cycles actually spent.
    logic [2:0]          flags;
  } ctmie_retire_t;

endpackage

/* core/ctmie_opdec.sv */
`timescale 1ns/100ps
`default_nettype none

// Pure table lookup from opcode to length, timing and flag effect.
module ctmie_opdec (
  input  wire logic [7:0]              opcode,
  output ctmie_pkg::ctmie_decode_t     dec
);

  // Length and cycle count per opcode; one-byte, one-cycle is the default.
  // register operands default
  always_comb
  begin
    dec           = '0;
    dec.legal     = 1'b1;
    dec.bytes     = 2'd1;
    dec.cyc_taken = 4'h1;
    case (opcode) inside
      // Indirect pointer operands: one byte, two cycles.
      // indirect two cycles
      8'h06, 8'h07, 8'h16, 8'h17, 8'h26, 8'h27, 8'h36, 8'h37, 8'h46, 8'h47,
      8'h56, 8'h57, 8'h66, 8'h67, 8'h96, 8'h97, [8'hC6:8'hC7], [8'hD6:8'hD7],
      [8'hE6:8'hE7], [8'hF6:8'hF7]:
        dec.cyc_taken = 4'h2;
      // Direct, immediate and bit operands: two bytes, two cycles.
      // bytes equal cycles
      8'h05, 8'h15, 8'h25, 8'h35, 8'h45, 8'h55, 8'h65, 8'h95, 8'hC5, 8'hE5, 8'hF5,
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h74, 8'h94,
      8'h42, 8'h52, 8'h62, 8'h72, 8'h82, 8'h92, 8'hA2, 8'hB2, 8'hC2, 8'hD2,
      8'hA0, 8'hB0, 8'hC0, 8'hD0, [8'h76:8'h7F], [8'h86:8'h8F], [8'hA6:8'hAF]:
      begin
        dec.bytes     = 2'd2;
        dec.cyc_taken = 4'h2;
      end
      // Three bytes, three cycles.
      // direct immediate three
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85, 8'h90:
      begin
        dec.bytes     = 2'd3;
        dec.cyc_taken = 4'h3;
      end
      // Code and external data moves, indirect jump: one byte, three cycles.
      8'h73, 8'h83, 8'h93, 8'hE0, [8'hE2:8'hE3], 8'hF0, [8'hF2:8'hF3]:
        dec.cyc_taken = 4'h3;
      // Absolute jumps and calls, short jump: two bytes, three cycles.
      8'h01, 8'h11, 8'h21, 8'h31, 8'h41, 8'h51, 8'h61, 8'h71,
      8'h81, 8'h91, 8'hA1, 8'hB1, 8'hC1, 8'hD1, 8'hE1, 8'hF1, 8'h80:
      begin
        dec.bytes     = 2'd2;
        dec.cyc_taken = 4'h3;
      end
      // Long jump and long call.
      8'h02, 8'h12:
      begin
        dec.bytes     = 2'd3;
        dec.cyc_taken = 4'h4;
      end
      // Returns.
      8'h22, 8'h32:
        dec.cyc_taken = 4'h5;
      // Multiply and divide.
      // longest is eight
      8'hA4:
        dec.cyc_taken = 4'h4;
      8'h84:
        dec.cyc_taken = 4'h8;
      // Conditional branches of two bytes: 2 not taken, 3 taken.
      // taken branch timing
      8'h40, 8'h50, 8'h60, 8'h70, [8'hD8:8'hDF]:
      begin
        dec.cond      = 1'b1;
        dec.bytes     = 2'd2;
        dec.cyc_taken = 4'h3;
      end
      // Conditional branches of three bytes: 3 not taken, 4 taken.
      8'h10, 8'h20, 8'h30, 8'hB4, [8'hB8:8'hBF], 8'hD5:
      begin
        dec.cond      = 1'b1;
        dec.bytes     = 2'd3;
        dec.cyc_taken = 4'h4;
      end
      // Compares that read memory: 4 not taken, 5 taken.
      [8'hB5:8'hB7]:
      begin
        dec.cond      = 1'b1;
        dec.bytes     = 2'd3;
        dec.cyc_taken = 4'h5;
      end
      ctmie_pkg::UNDEFINED_OPCODE:
        dec.legal = 1'b0;
      default:
        dec.legal = 1'b1;
    endcase
    // Status word flags written by each opcode, as in the classic set.
    if (opcode inside {[8'h24:8'h2F], [8'h34:8'h3F], [8'h94:8'h9F]})
      dec.flags = 3'b111;
    else if (opcode inside {8'h84, 8'hA4})
      dec.flags = 3'b101;
    else if (opcode inside {8'hD4, 8'h13, 8'h33, [8'hB3:8'hBF], 8'hC3, 8'hD3,
                            8'h72, 8'h82, 8'hA0, 8'hB0, 8'hA2})
      dec.flags = 3'b100;
    else
      dec.flags = 3'b000;
  end

endmodule

`default_nettype wire

/* core/ctmie_cycle_timer.sv */
`timescale 1ns/100ps
`default_nettype none

// Counts the cycles an instruction still owns after its first one.
module ctmie_cycle_timer #(
  parameter int unsigned CYCLES_W = 4
) (
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire logic                load,
  input  wire logic [CYCLES_W-1:0] load_cycles,
  output logic                     idle_q,
  output logic                     last
);

  logic [CYCLES_W-1:0] remain_q;
  logic [CYCLES_W-1:0] remain_d;

  // A load covers the current cycle, so the count left is one less.
  always_comb
  begin
    if (load)
      remain_d = load_cycles - CYCLES_W'(1);
    else if (remain_q != '0)
      remain_d = remain_q - CYCLES_W'(1);
    else
      remain_d = remain_q;
  end

  // Final cycle of the running instruction, or a one-cycle one just issued.
  assign last = load ? (load_cycles == CYCLES_W'(1)) : (remain_q == CYCLES_W'(1));

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      remain_q <= '0;
    else
      remain_q <= remain_d;
  end

  // Idle is registered from the next count so the top can use it as an output.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      idle_q <= 1'b1;
    else
      idle_q <= (remain_d == '0);
  end

endmodule

`default_nettype wire

/* core/ctmie_exec.sv */
// Behaviour
// - Decode opcodes, modes and flags as classic
// - Time everything in plain system clocks
// - Most instructions: cycles equal program bytes
// - Failed conditional branch finishes one cycle sooner
// - At most eight cycles; most take one or two
// - Accumulator with working register: 1 byte, 1 cycle
// - Indirect pointer operand: 1 byte, 2 cycles
// - Immediate or direct to accumulator: 2, 2
// - Immediate into direct byte: 3 bytes, 3
// - Accumulator into direct byte: 2 bytes, 2
// - All 109 instructions have a clock count
`timescale 1ns/100ps
`default_nettype none

// Instruction issue and cycle timing of the core, which runs one instruction at a time.
module ctmie_exec #(
  parameter int unsigned MAX_CYCLES = 8
) (
  input  wire logic                    ref_clk,
  input  wire logic                    resetn,
  input  wire logic                    issue_valid,
  input  wire logic [7:0]              issue_opcode,
  input  wire logic                    branch_cond,
  output logic                         issue_ready_q,
  output ctmie_pkg::ctmie_retire_t     retire_q
);

  // The timer and the retire record are four bits wide; wider waits cannot fit.
  if (MAX_CYCLES < 1 || MAX_CYCLES > 15)
    $error("ctmie_exec: MAX_CYCLES must lie between 1 and 15");

  ctmie_pkg::ctmie_decode_t dec;
  ctmie_pkg::ctmie_retire_t pend_q;
  ctmie_pkg::ctmie_retire_t issue_rec;
  logic                     issue_fire;
  logic                     timer_idle_q;
  logic                     timer_last;
  logic                     taken;
  logic [3:0]               eff_cycles;

  ctmie_opdec u_opdec (
    .opcode (issue_opcode),
    .dec    (dec)
  );

  assign issue_fire = issue_valid && issue_ready_q;

  // A non-conditional instruction counts as taken so its record reads uniformly.
  assign taken = !dec.cond || branch_cond;

  always_comb
  begin
    if (!dec.legal)
      eff_cycles = ctmie_pkg::ONE_CYCLE;
    else if (dec.cond && !branch_cond)
      eff_cycles = dec.cyc_taken - ctmie_pkg::NOT_TAKEN_SAVING;
    else
      eff_cycles = dec.cyc_taken;
  end

  // Record of the instruction being issued, held until it completes.
  always_comb
  begin
    issue_rec         = '0;
    issue_rec.valid   = 1'b1;
    issue_rec.illegal = !dec.legal;
    issue_rec.taken   = taken;
    issue_rec.opcode  = issue_opcode;
    issue_rec.bytes   = dec.bytes;
    issue_rec.cycles  = eff_cycles;
    issue_rec.flags   = dec.legal ? dec.flags : 3'b000;
  end

  ctmie_cycle_timer #(
    .CYCLES_W (ctmie_pkg::CYCLES_W)
  ) u_timer (
    .ref_clk     (ref_clk),
    .resetn      (resetn),
    .load        (issue_fire),
    .load_cycles (eff_cycles),
    .idle_q      (timer_idle_q),
    .last        (timer_last)
  );

  // The ready output is the timer's own flop, so there is no extra latency.
  assign issue_ready_q = timer_idle_q;

  // Keep the record of a multi-cycle instruction until its final cycle.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      pend_q <= '0;
    else if (issue_fire)
      pend_q <= issue_rec;
  end

  // Completion pulse in the cycle after the last cycle of the instruction.
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      retire_q <= '0;
    else if (issue_fire && timer_last)
      retire_q <= issue_rec;
    else if (timer_last)
      retire_q <= pend_q;
    else
      retire_q <= '0;
  end

  // Helper: cycles since the last issue, read only by the checks below.
  logic [3:0] since_issue_q;

  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
      since_issue_q <= '0;
    else if (issue_fire)
      since_issue_q <= 4'h1;
    else if (since_issue_q != 4'hF)
      since_issue_q <= since_issue_q + 4'h1;
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!resetn);

  // Completion comes exactly as many cycles after issue as the instruction owns.
  a_retire_spacing: assert property (
    retire_q.valid |-> since_issue_q == retire_q.cycles)
    else $error("retire does not match cycles spent since issue");

  // A one-cycle instruction leaves the core ready and completes next cycle.
  a_single_cycle: assert property (
    issue_fire && issue_opcode inside {[8'h28:8'h2F], [8'h38:8'h3F], [8'h48:8'h4F],
      [8'h58:8'h5F], [8'h68:8'h6F], [8'h98:8'h9F]}
    |=> retire_q.valid && retire_q.cycles == 4'h1 && retire_q.bytes == 2'd1
        && issue_ready_q)
    else $error("register operand instruction not one byte one cycle");

  // Indirect operands stall the next issue for exactly one cycle.
  a_indirect_two: assert property (
    issue_fire && issue_opcode inside {[8'h26:8'h27], [8'h36:8'h37], [8'h46:8'h47],
      [8'h56:8'h57], [8'h66:8'h67], [8'h96:8'h97]}
    |=> !issue_ready_q ##1 issue_ready_q && retire_q.valid && retire_q.bytes == 2'd1)
    else $error("indirect operand instruction not two cycles");

  // Immediate and direct operands to the accumulator take two bytes, two cycles.
  a_imm_direct: assert property (
    issue_fire && issue_opcode inside {8'h24, 8'h25, 8'h44, 8'h45, 8'h54, 8'h55,
      8'h64, 8'h65, 8'h94, 8'h95}
    |=> !retire_q.valid ##1 retire_q.valid && retire_q.cycles == 4'h2
        && retire_q.bytes == 2'd2)
    else $error("immediate or direct accumulator operation not two cycles");

  // Immediate into a direct byte takes three bytes and three cycles.
  a_direct_imm: assert property (
    issue_fire && issue_opcode inside {8'h43, 8'h53, 8'h63}
    |=> !issue_ready_q [*2] ##1 issue_ready_q && retire_q.cycles == 4'h3
        && retire_q.bytes == 2'd3)
    else $error("immediate into direct byte not three cycles");

  // Accumulator into a direct byte takes two bytes and two cycles.
  a_acc_direct: assert property (
    issue_fire && issue_opcode inside {8'h42, 8'h52, 8'h62}
    |=> ##1 retire_q.valid && retire_q.cycles == 4'h2 && retire_q.bytes == 2'd2)
    else $error("accumulator into direct byte not two cycles");

  // A failed branch retires one cycle earlier than the taken one would.
  a_branch_saving: assert property (
    issue_fire && dec.cond && !branch_cond
    |-> eff_cycles + ctmie_pkg::NOT_TAKEN_SAVING == dec.cyc_taken
        && eff_cycles >= 4'h2)
    else $error("not-taken branch does not save one cycle");

  // No completion ever reports more than the longest allowed time.
  a_cycle_ceiling: assert property (
    retire_q.valid |-> retire_q.cycles >= 4'h1
        && retire_q.cycles <= 4'(MAX_CYCLES))
    else $error("instruction exceeded the cycle ceiling");

  // Divide owns the core for eight cycles with ready held low in between.
  a_divide_eight: assert property (
    issue_fire && issue_opcode == 8'h84
    |=> !issue_ready_q [*7] ##1 issue_ready_q && retire_q.cycles == 4'h8)
    else $error("divide does not take eight cycles");

  // While busy, the core is not ready and no second record can be taken.
  a_hold_off: assert property (
    !issue_ready_q |-> !issue_fire && since_issue_q >= 4'h1 && since_issue_q < pend_q.cycles)
    else $error("issue accepted while an instruction is running");

  // Most short instructions keep cycles equal to program bytes.
  a_bytes_cycles: assert property (
    issue_fire && issue_opcode inside {8'h75, 8'h85, 8'h90, 8'hC0, 8'hD0}
    |-> eff_cycles == 4'(dec.bytes))
    else $error("byte count and cycle count differ");

  // Arithmetic writes carry, auxiliary carry and overflow as in the classic set.
  a_arith_flags: assert property (
    issue_fire && issue_opcode inside {[8'h24:8'h2F]}
    |=> ##[0:1] retire_q.valid && retire_q.flags == 3'b111)
    else $error("addition does not report its flag effects");

  // Only the undefined opcode is flagged as illegal.
  a_one_illegal: assert property (
    issue_fire |-> (!dec.legal) == (issue_opcode == ctmie_pkg::UNDEFINED_OPCODE))
    else $error("illegal marking does not match the undefined opcode");

  // A failed two-byte branch frees the core after two cycles.
  a_short_branch2: assert property (
    issue_fire && !branch_cond
    && issue_opcode inside {8'h40, 8'h50, 8'h60, 8'h70, [8'hD8:8'hDF]}
    |=> !issue_ready_q ##1 issue_ready_q && retire_q.valid && !retire_q.taken
        && retire_q.cycles == 4'h2)
    else $error("failed short branch not two cycles");

  // A failed three-byte branch that reads no memory takes three cycles.
  a_short_branch3: assert property (
    issue_fire && !branch_cond
    && issue_opcode inside {8'h10, 8'h20, 8'h30, 8'hB4, [8'hB8:8'hBF], 8'hD5}
    |=> !issue_ready_q [*2] ##1 issue_ready_q && retire_q.valid && !retire_q.taken
        && retire_q.cycles == 4'h3 && retire_q.bytes == 2'd3)
    else $error("failed long branch not three cycles");

  // A taken two-byte branch holds the core one cycle longer than a failed one.
  a_taken_branch: assert property (
    issue_fire && branch_cond
    && issue_opcode inside {8'h40, 8'h50, 8'h60, 8'h70, [8'hD8:8'hDF]}
    |=> !issue_ready_q [*2] ##1 retire_q.valid && retire_q.taken && retire_q.cycles == 4'h3)
    else $error("taken short branch not three cycles");

  // Compares that read memory take four cycles when they fall through.
  a_cmp_mem_branch: assert property (
    issue_fire && !branch_cond && issue_opcode inside {[8'hB5:8'hB7]}
    |=> !issue_ready_q [*3] ##1 retire_q.valid && !retire_q.taken && retire_q.cycles == 4'h4)
    else $error("failed memory compare not four cycles");

  // A record only leaves the core when the core is free for the next one.
  a_retire_ready: assert property (
    retire_q.valid |-> issue_ready_q)
    else $error("record completed while the core is busy");

  // Between completions the record is all zero, so stale fields never leak out.
  a_quiet_record: assert property (
    !retire_q.valid |-> retire_q == '0)
    else $error("record fields set without a completion");

  // The undefined opcode runs as a one-cycle no-op that writes no flags.
  a_illegal_noop: assert property (
    issue_fire && issue_opcode == ctmie_pkg::UNDEFINED_OPCODE
    |=> retire_q.valid && retire_q.illegal && retire_q.cycles == 4'h1
        && retire_q.flags == 3'b000 && issue_ready_q)
    else $error("undefined opcode not a one-cycle no-op");

  // Multiply owns the core for four cycles and writes carry and overflow.
  a_mul_four: assert property (
    issue_fire && issue_opcode == 8'hA4
    |=> !issue_ready_q [*3] ##1 issue_ready_q && retire_q.cycles == 4'h4
        && retire_q.flags == 3'b101)
    else $error("multiply not four cycles");

  // Returns are one byte long but take five cycles.
  a_return_five: assert property (
    issue_fire && issue_opcode inside {8'h22, 8'h32}
    |=> !issue_ready_q [*4] ##1 retire_q.valid && retire_q.cycles == 4'h5
        && retire_q.bytes == 2'd1)
    else $error("return not five cycles");

  // Long jump and long call take three bytes and four cycles.
  a_long_jump: assert property (
    issue_fire && issue_opcode inside {8'h02, 8'h12}
    |=> !issue_ready_q [*3] ##1 retire_q.valid && retire_q.cycles == 4'h4
        && retire_q.bytes == 2'd3)
    else $error("long jump or call not four cycles");

  // Code and external data moves are one byte that still needs three cycles.
  a_code_move: assert property (
    issue_fire && issue_opcode inside {8'h73, 8'h83, 8'h93, 8'hE0, [8'hE2:8'hE3], 8'hF0,
      [8'hF2:8'hF3]}
    |=> !issue_ready_q [*2] ##1 retire_q.valid && retire_q.cycles == 4'h3
        && retire_q.bytes == 2'd1)
    else $error("code or external move not three cycles");

  // Absolute jumps and calls and the short jump take two bytes and three cycles.
  a_call_jump: assert property (
    issue_fire && (issue_opcode[3:0] == 4'h1 || issue_opcode == 8'h80)
    |=> !issue_ready_q [*2] ##1 retire_q.valid && retire_q.cycles == 4'h3
        && retire_q.bytes == 2'd2 && retire_q.taken)
    else $error("absolute or short jump not three cycles");

  // Carry-only instructions report the carry flag and nothing else.
  a_carry_flags: assert property (
    issue_fire && issue_opcode inside {8'h13, 8'h33, 8'h72, 8'h82, 8'hA0, 8'hA2, 8'hB0,
      8'hB3, 8'hC3, 8'hD3, 8'hD4}
    |=> ##[0:1] retire_q.valid && retire_q.flags == 3'b100)
    else $error("carry instruction does not report carry only");

  // Plain moves leave every status flag alone.
  a_move_no_flags: assert property (
    issue_fire && issue_opcode inside {8'h74, 8'hE5, [8'hE8:8'hEF], [8'hF8:8'hFF], 8'hF5}
    |=> ##[0:1] retire_q.valid && retire_q.flags == 3'b000)
    else $error("move reports a flag effect");

  // Main scenarios: branches both ways, the longest, back-to-back and undefined.
  c_branch_taken: cover property (issue_fire && dec.cond && branch_cond);
  c_branch_failed: cover property (issue_fire && dec.cond && !branch_cond);
  c_divide: cover property (issue_fire && issue_opcode == 8'h84);
  c_back_to_back: cover property (issue_fire ##1 issue_fire);
  c_illegal: cover property (issue_fire && !dec.legal);

endmodule

`default_nettype wire

/* tb/ctmie_prog_mem.sv */
`timescale 1ns/100ps
`default_nettype none

// Program memory side: offers one opcode at a time and holds it until the core takes it.
module ctmie_prog_mem (
  input  wire logic       ref_clk,
  input  wire logic       issue_ready_q,
  output var  logic       issue_valid,
  output var  logic [7:0] issue_opcode,
  output var  logic       branch_cond
);

  // Quiet bus at time zero so the core never sees an unknown request.
  initial
  begin
    issue_valid  = 1'b0;
    issue_opcode = 8'h00;
    branch_cond  = 1'b0;
  end

  // Called just after a rising edge; returns right after the edge that took the request.
  // Requests made while the core is busy stay up, so refused cycles are exercised too.
  task automatic issue(input logic [7:0] op, input logic c);
    issue_valid  <= 1'b1;
    issue_opcode <= op;
    branch_cond  <= c;
    #1;
    while (issue_ready_q !== 1'b1)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
  endtask

  // A released bus shows inverted values, so a core that keeps sampling it is caught.
  task automatic idle();
    issue_valid  <= 1'b0;
    issue_opcode <= ~issue_opcode;
    branch_cond  <= ~branch_cond;
  endtask

endmodule

`default_nettype wire

/* tb/tb_cycle_timed_mcu_instruction_exec.sv */
`timescale 1ns/100ps
`default_nettype none

module tb_cycle_timed_mcu_instruction_exec;

  logic                      ref_clk;
  logic                      resetn;
  logic                      issue_valid;
  logic [7:0]                issue_opcode;
  logic                      branch_cond;
  logic                      issue_ready_q;
  ctmie_pkg::ctmie_retire_t  retire_q;
  int                        fails;
  int                        num_checks;

  // Free-running 50 MHz system clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  ctmie_prog_mem i_mem (
    .ref_clk       (ref_clk),
    .issue_ready_q (issue_ready_q),
    .issue_valid   (issue_valid),
    .issue_opcode  (issue_opcode),
    .branch_cond   (branch_cond)
  );

  ctmie_exec #(.MAX_CYCLES(8)) i_dut (
    .ref_clk       (ref_clk),
    .resetn        (resetn),
    .issue_valid   (issue_valid),
    .issue_opcode  (issue_opcode),
    .branch_cond   (branch_cond),
    .issue_ready_q (issue_ready_q),
    .retire_q      (retire_q)
  );

  // Expected retire record, in the field order of the package struct.
  function automatic ctmie_pkg::ctmie_retire_t ex(input logic [7:0] op, input logic [1:0] by,
    input logic [3:0] cy, input logic [2:0] fl, input logic tk, input logic il);
    ex = {1'b1, il, tk, op, by, cy, fl};
  endfunction

  task automatic chk_r(input ctmie_pkg::ctmie_retire_t e);
    num_checks++;
    if (retire_q !== e)
    begin
      fails++;
      $display("mismatch retire_q expected %h seen %h", e, retire_q);
    end
  endtask

  task automatic chk_b(input logic seen, input logic e);
    num_checks++;
    if (seen !== e)
    begin
      fails++;
      $display("mismatch issue_ready_q expected %b seen %b", e, seen);
    end
  endtask

  // Issues r1 (and r2 right behind it when two is set) and checks every cycle.
  // Sampling on the falling edge keeps the checks clear of the flops' update.
  task automatic run(input ctmie_pkg::ctmie_retire_t r1, input logic c1,
                     input ctmie_pkg::ctmie_retire_t r2, input logic two);
    int n;
    n = int'(r1.cycles);
    @(posedge ref_clk);
    fork
      begin
        i_mem.issue(r1.opcode, c1);
        if (two)
          i_mem.issue(r2.opcode, 1'b0);
        i_mem.idle();
      end
    join_none
    for (int k = 0; k <= n + 2; k++)
    begin
      @(negedge ref_clk);
      chk_r((k == n) ? r1 : ((two && k == n + 1) ? r2 : '0));
      if (k >= 1 && k <= n)
        chk_b(issue_ready_q, k == n);
    end
  endtask

  task automatic t_register();
    run(ex(8'h28, 2'h1, 4'h1, 3'h7, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h3F, 2'h1, 4'h1, 3'h7, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test register done");
  endtask

  task automatic t_indirect();
    run(ex(8'h26, 2'h1, 4'h2, 3'h7, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h97, 2'h1, 4'h2, 3'h7, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    run(ex(8'h57, 2'h1, 4'h2, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test indirect done");
  endtask

  task automatic t_imm_direct();
    run(ex(8'h24, 2'h2, 4'h2, 3'h7, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h65, 2'h2, 4'h2, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test imm_direct done");
  endtask

  task automatic t_direct_dest();
    run(ex(8'h53, 2'h3, 4'h3, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h43, 2'h3, 4'h3, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h42, 2'h2, 4'h2, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h62, 2'h2, 4'h2, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test direct_dest done");
  endtask

  task automatic t_branch();
    run(ex(8'h60, 2'h2, 4'h3, 3'h0, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    run(ex(8'h60, 2'h2, 4'h2, 3'h0, 1'b0, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'hB5, 2'h3, 4'h5, 3'h4, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    run(ex(8'hB5, 2'h3, 4'h4, 3'h4, 1'b0, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h20, 2'h3, 4'h3, 3'h0, 1'b0, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h40, 2'h2, 4'h3, 3'h0, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    $display("test branch done");
  endtask

  task automatic t_longest();
    run(ex(8'h84, 2'h1, 4'h8, 3'h5, 1'b1, 1'b0), 1'b0,
        ex(8'h04, 2'h1, 4'h1, 3'h0, 1'b1, 1'b0), 1'b1);
    run(ex(8'hA4, 2'h1, 4'h4, 3'h5, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test longest done");
  endtask

  task automatic t_back2back();
    run(ex(8'h04, 2'h1, 4'h1, 3'h0, 1'b1, 1'b0), 1'b0,
        ex(8'h14, 2'h1, 4'h1, 3'h0, 1'b1, 1'b0), 1'b1);
    $display("test back2back done");
  endtask

  task automatic t_illegal();
    run(ex(8'hA5, 2'h1, 4'h1, 3'h0, 1'b1, 1'b1), 1'b1, '0, 1'b0);
    $display("test illegal done");
  endtask

  // Other timing classes: returns, long jumps, code moves, calls, carry and moves.
  task automatic t_classes();
    run(ex(8'h22, 2'h1, 4'h5, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h02, 2'h3, 4'h4, 3'h0, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    run(ex(8'h73, 2'h1, 4'h3, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h11, 2'h2, 4'h3, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'h13, 2'h1, 4'h1, 3'h4, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    run(ex(8'hE8, 2'h1, 4'h1, 3'h0, 1'b1, 1'b0), 1'b1, '0, 1'b0);
    $display("test classes done");
  endtask

  // a reset in the middle of a long instruction leaves the core idle.
  task automatic t_reset();
    @(posedge ref_clk);
    i_mem.issue(8'h84, 1'b0);
    i_mem.idle();
    @(negedge ref_clk);
    chk_b(issue_ready_q, 1'b0);
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(negedge ref_clk);
    chk_r('0);
    chk_b(issue_ready_q, 1'b1);
    @(posedge ref_clk);
    resetn <= 1'b1;
    run(ex(8'h04, 2'h1, 4'h1, 3'h0, 1'b1, 1'b0), 1'b0, '0, 1'b0);
    $display("test reset done");
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence: reset, check the idle state, then every scenario.
  initial
  begin
    fails      = 0;
    num_checks = 0;
    resetn     = 1'b0;
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(negedge ref_clk);
    chk_r('0);
    chk_b(issue_ready_q, 1'b1);
    t_register();
    t_indirect();
    t_imm_direct();
    t_direct_dest();
    t_branch();
    t_longest();
    t_back2back();
    t_illegal();
    t_classes();
    t_reset();
    wrap_up();
  end

  // The scenarios need about 180 cycles; a hang is cut off far beyond that.
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    fails++;
    wrap_up();
  end

endmodule

`default_nettype wire
